/* logic/ccs_clock_source_control.sv */
`timescale 1ns/1ps
`include "ccs_defs.svh"

// Summary of operation
// - Bypass plus enable passes input pin through.
// - Fast crystal runs only while enabled.
// - Fast external gated until stable, then ready.
// - Fast external ready raises enabled interrupt request.
// - Slow bypass plus enable passes pin through.
// - Slow crystal follows slow external enable.
// - Slow external blocked until ready flag set.
// - Slow external ready raises enabled interrupt request.
// - Fast internal RC nominal 8 MHz.
// - First edge after reset loads factory calibration value.
// - Software trim adjusts fast RC frequency.
// - Fast RC gated until ready flag set.
// - Fast RC follows its enable bit outside stop and standby.
// - Slow RC follows its enable bit or the watchdog force.
// - Slow RC withheld until ready flag set.
// - Slow RC ready raises enabled interrupt request.
// - Slow RC keeps running in stop, standby.
module ccs_clock_source_control #(
    parameter int unsigned FXO_START_EDGES = `CCS_FXO_START_EDGES,
    parameter int unsigned SXO_START_EDGES = `CCS_SXO_START_EDGES,
    parameter int unsigned FRC_START_CYC   = `CCS_FRC_START_CYC,
    parameter int unsigned SRC_START_CYC   = `CCS_SRC_START_CYC
) (
    input  wire logic                   core_clk,
    input  wire logic                   arst_n,
    // Oscillator pins
    input  wire logic                   fast_osc_input_pin,
    output logic                        fast_osc_output_pin_en,
    input  wire logic                   slow_osc_input_pin,
    output logic                        slow_osc_output_pin_en,
    // Control bits
    input  wire logic                   fast_ext_osc_enable,
    input  wire logic                   fast_ext_bypass_select,
    input  wire logic                   slow_ext_osc_enable,
    input  wire logic                   slow_ext_bypass_select,
    input  wire logic                   fast_rc_enable,
    input  wire logic [`CCS_TRIM_W-1:0] fast_rc_trim,
    input  wire logic                   slow_rc_enable,
    input  wire logic                   watchdog_force_slow_rc,
    input  wire logic                   deep_low_power,
    input  wire logic [`CCS_CAL_W-1:0]  factory_cal,
    input  wire ccs_pkg::ccs_src_bits_t ready_irq_enable,
    // Status
    output logic [`CCS_CAL_W-1:0]       fast_rc_cal,
    output ccs_pkg::ccs_src_bits_t      ready_flags,
    output ccs_pkg::ccs_src_bits_t      ready_irq_req,
    // Gated clocks
    output logic                        fast_external_clock,
    output logic                        slow_external_clock,
    output logic                        fast_internal_rc_clock,
    output logic                        slow_internal_rc_clock
);

    // ==========================================================
    // Synchronised pins and state
    logic                   fast_pin_s;
    logic                   slow_pin_s;
    wire ccs_pkg::ccs_src_bits_t rdy;
    ccs_pkg::ccs_src_bits_t run;
    ccs_pkg::ccs_top_state_t state_reg;
    ccs_pkg::ccs_top_state_t state_next;
    logic                   fast_edge;
    logic                   slow_edge;
    logic                   frc_tick;
    logic                   src_tick;

    ccs_sync2 u_sync_fast (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .async_in (fast_osc_input_pin),
        .sync_out (fast_pin_s)
    );

    ccs_sync2 u_sync_slow (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .async_in (slow_osc_input_pin),
        .sync_out (slow_pin_s)
    );

    // ==========================================================
    // Fast RC half period from calibration and trim.
    // Trim is centred on its reset value; calibration on its midpoint,
    // scaled down so the factory step is finer than the user step.
    function automatic logic [`CCS_CNT_W-1:0] ccs_frc_half(
        input logic [`CCS_CAL_W-1:0]  cal,
        input logic [`CCS_TRIM_W-1:0] trim
    );
        int signed v;
        v = int'(`CCS_FRC_HALF_CYC)
            + (int'(trim) - int'(`CCS_TRIM_RST))
            + ((int'(cal) - int'(`CCS_CAL_MID)) >>> `CCS_CAL_SHIFT);
        if (v < 1) begin
            v = 1;
        end
        return `CCS_CNT_W'(v - 1);
    endfunction

    // Down counter with reload; returns the next count, and zero is detected separately as the tick
    function automatic logic [`CCS_CNT_W-1:0] ccs_count_down(
        input logic [`CCS_CNT_W-1:0] cnt,
        input logic [`CCS_CNT_W-1:0] reload
    );
        return (cnt == '0) ? reload : cnt - `CCS_CNT_W'(1);
    endfunction

    // ==========================================================
    // Effective enables
    always_comb begin
        // Stop and standby shut the fast sources down
        // fast crystal enable
        run.fxo = fast_ext_osc_enable && !deep_low_power;
        run.sxo = slow_ext_osc_enable;
        run.frc = fast_rc_enable && !deep_low_power;
        run.src = slow_rc_enable || watchdog_force_slow_rc;
    end

    // Crystal amplifiers drive the output pins; bypass leaves them floating
    assign fast_osc_output_pin_en = run.fxo && !fast_ext_bypass_select;
    assign slow_osc_output_pin_en = run.sxo && !slow_ext_bypass_select;

    assign fast_edge = fast_pin_s && !state_reg.fast_prev;
    assign slow_edge = slow_pin_s && !state_reg.slow_prev;
    assign frc_tick  = run.frc && (state_reg.frc_cnt == '0);
    assign src_tick  = run.src && (state_reg.src_cnt == '0);

    // ==========================================================
    // Next state
    always_comb begin
        state_next           = state_reg;
        state_next.fast_prev = fast_pin_s;
        state_next.slow_prev = slow_pin_s;

        if (!state_reg.cal_taken) begin
            state_next.cal       = factory_cal;
            state_next.cal_taken = 1'b1;
        end

        if (run.frc) begin
            state_next.frc_cnt = ccs_count_down(state_reg.frc_cnt,
                                                ccs_frc_half(state_reg.cal, fast_rc_trim));
            if (frc_tick) begin
                state_next.frc_lvl = !state_reg.frc_lvl;
            end
        end else begin
            state_next.frc_cnt = '0;
            state_next.frc_lvl = 1'b0;
        end

        if (run.src) begin
            state_next.src_cnt = ccs_count_down(state_reg.src_cnt,
                                                `CCS_CNT_W'(`CCS_SRC_HALF_CYC - 1));
            if (src_tick) begin
                state_next.src_lvl = !state_reg.src_lvl;
            end
        end else begin
            state_next.src_cnt = '0;
            state_next.src_lvl = 1'b0;
        end

        // Requests fire once, on the rising edge of each ready flag
        state_next.ready_prev = rdy;
        state_next.irq.fxo = rdy.fxo && !state_reg.ready_prev.fxo && ready_irq_enable.fxo;
        state_next.irq.sxo = rdy.sxo && !state_reg.ready_prev.sxo && ready_irq_enable.sxo;
        state_next.irq.frc = rdy.frc && !state_reg.ready_prev.frc && ready_irq_enable.frc;
        state_next.irq.src = rdy.src && !state_reg.ready_prev.src && ready_irq_enable.src;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // Per-source startup and gating
    // fast bypass passes pin
    ccs_src_ready #(
        .START_COUNT (FXO_START_EDGES)
    ) u_rdy_fxo (
        .core_clk   (core_clk),
        .arst_n     (arst_n),
        .enable     (run.fxo),
        .stable_evt (fast_edge),
        .src_level  (fast_pin_s),
        .ready      (rdy.fxo),
        .clk_gated  (fast_external_clock)
    );

    ccs_src_ready #(
        .START_COUNT (SXO_START_EDGES)
    ) u_rdy_sxo (
        .core_clk   (core_clk),
        .arst_n     (arst_n),
        .enable     (run.sxo),
        .stable_evt (slow_edge),
        .src_level  (slow_pin_s),
        .ready      (rdy.sxo),
        .clk_gated  (slow_external_clock)
    );

    ccs_src_ready #(
        .START_COUNT (FRC_START_CYC)
    ) u_rdy_frc (
        .core_clk   (core_clk),
        .arst_n     (arst_n),
        .enable     (run.frc),
        .stable_evt (1'b1),
        .src_level  (state_reg.frc_lvl),
        .ready      (rdy.frc),
        .clk_gated  (fast_internal_rc_clock)
    );

    ccs_src_ready #(
        .START_COUNT (SRC_START_CYC)
    ) u_rdy_src (
        .core_clk   (core_clk),
        .arst_n     (arst_n),
        .enable     (run.src),
        .stable_evt (1'b1),
        .src_level  (state_reg.src_lvl),
        .ready      (rdy.src),
        .clk_gated  (slow_internal_rc_clock)
    );

    // ==========================================================
    // Status outputs
    assign ready_flags   = rdy;
    assign ready_irq_req = state_reg.irq;
    assign fast_rc_cal   = state_reg.cal;

endmodule // ccs_clock_source_control

/* pkg/ccs_defs.svh */
`ifndef CCS_DEFS_SVH
`define CCS_DEFS_SVH

// ==========================================================
// Clock and oscillator rates
`define CCS_CLK_HZ          200000000
`define CCS_FRC_HZ          8000000
`define CCS_SRC_HZ          40000
// Half periods in core cycles, rounded down
`define CCS_FRC_HALF_CYC    (`CCS_CLK_HZ / (2 * `CCS_FRC_HZ))
`define CCS_SRC_HALF_CYC    (`CCS_CLK_HZ / (2 * `CCS_SRC_HZ))

// ==========================================================
// Startup times of the internal oscillators, rounded up to cycles
`define CCS_FRC_START_NS    2000
`define CCS_FRC_START_CYC   ((`CCS_FRC_START_NS * (`CCS_CLK_HZ / 1000000) + 999) / 1000)
`define CCS_SRC_START_NS    85000
`define CCS_SRC_START_CYC   ((`CCS_SRC_START_NS * (`CCS_CLK_HZ / 1000000) + 999) / 1000)

// ==========================================================
// Startup counts of the external sources, in input rising edges
`define CCS_FXO_START_EDGES 2048
`define CCS_SXO_START_EDGES 1024

// ==========================================================
// Trim and calibration fields
`define CCS_TRIM_W          5
`define CCS_CAL_W           8
`define CCS_TRIM_RST        5'h10
`define CCS_CAL_MID         8'h80
`define CCS_CAL_SHIFT       4
`define CCS_CNT_W           16

`endif

/* pkg/ccs_pkg.sv */
`include "ccs_defs.svh"

package ccs_pkg;

    // One bit per clock source
    typedef struct packed {
        logic fxo;
        logic sxo;
        logic frc;
        logic src;
    } ccs_src_bits_t;

    typedef struct packed {
        logic s2;
        logic s1;
    } ccs_sync_t;

    typedef enum logic [1:0] {
        CCS_OFF,
        CCS_START,
        CCS_RUN,
        CCS_STOP
    } ccs_phase_t;

    typedef struct packed {
        ccs_phase_t                phase;
        logic [`CCS_CNT_W-1:0]     cnt;
        logic                      ready;
        logic                      clk_out;
    } ccs_rdy_state_t;

    typedef struct packed {
        logic                      fast_prev;
        logic                      slow_prev;
        logic [`CCS_CNT_W-1:0]     frc_cnt;
        logic                      frc_lvl;
        logic [`CCS_CNT_W-1:0]     src_cnt;
        logic                      src_lvl;
        logic [`CCS_CAL_W-1:0]     cal;
        logic                      cal_taken;
        ccs_src_bits_t             ready_prev;
        ccs_src_bits_t             irq;
    } ccs_top_state_t;

endpackage

/* logic/ccs_sync2.sv */
`timescale 1ns/1ps

// ==========================================================
// Two-flop synchroniser for a pin level
module ccs_sync2 (
    input  wire logic core_clk,
    input  wire logic arst_n,
    input  wire logic async_in,
    output logic      sync_out
);

    ccs_pkg::ccs_sync_t state_reg;
    ccs_pkg::ccs_sync_t state_next;

    always_comb begin
        state_next.s1 = async_in;
        state_next.s2 = state_reg.s1;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_out = state_reg.s2;

endmodule // ccs_sync2

/* logic/ccs_src_ready.sv */
`timescale 1ns/1ps
`include "ccs_defs.svh"

// ==========================================================
// Startup, ready flag and output gate of one clock source
module ccs_src_ready #(
    parameter int unsigned START_COUNT = 16
) (
    input  wire logic core_clk,
    input  wire logic arst_n,
    input  wire logic enable,
    input  wire logic stable_evt,
    input  wire logic src_level,
    output logic      ready,
    output logic      clk_gated
);

    localparam logic [`CCS_CNT_W-1:0] LAST = `CCS_CNT_W'(START_COUNT - 1);

    ccs_pkg::ccs_rdy_state_t state_reg;
    ccs_pkg::ccs_rdy_state_t state_next;

    always_comb begin
        state_next = state_reg;
        case (state_reg.phase)
            ccs_pkg::CCS_OFF: begin
                state_next.cnt   = '0;
                state_next.ready = 1'b0;
                if (enable) begin
                    state_next.phase = ccs_pkg::CCS_START;
                end
            end
            ccs_pkg::CCS_START: begin
                if (!enable) begin
                    state_next.phase = ccs_pkg::CCS_OFF;
                end else if (stable_evt) begin
                    if (state_reg.cnt == LAST) begin
                        state_next.phase = ccs_pkg::CCS_RUN;
                        state_next.ready = 1'b1;
                    end else begin
                        state_next.cnt = state_reg.cnt + `CCS_CNT_W'(1);
                    end
                end
            end
            ccs_pkg::CCS_RUN: begin
                if (!enable) begin
                    state_next.phase = ccs_pkg::CCS_STOP;
                end
            end
            ccs_pkg::CCS_STOP: begin
                // Gate already closed; flag drops one cycle later
                state_next.ready = 1'b0;
                state_next.phase = ccs_pkg::CCS_OFF;
            end
            default: begin
                state_next.phase = ccs_pkg::CCS_OFF;
            end
        endcase
        state_next.clk_out = (state_next.phase == ccs_pkg::CCS_RUN) && src_level;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= '{phase: ccs_pkg::CCS_OFF, cnt: '0, ready: 1'b0, clk_out: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign ready     = state_reg.ready;
    assign clk_gated = state_reg.clk_out;

endmodule // ccs_src_ready

/* test/ccs_osc_model.sv */
`timescale 1ns/1ps

// ==========================================================
// Off-chip oscillators for both external sources
// Slow half period is scaled down so startup stays short
module ccs_osc_model #(
    parameter int FAST_HALF = 20,
    parameter int SLOW_HALF = 40
) (
    input  wire logic fast_run,
    input  wire logic slow_run,
    output logic      fast_pin,
    output logic      slow_pin
);
    initial begin
        fast_pin = 1'b0;
        slow_pin = 1'b0;
    end

    always #(FAST_HALF) if (fast_run) fast_pin = ~fast_pin;
    always #(SLOW_HALF) if (slow_run) slow_pin = ~slow_pin;

    // A stopped pin floats; show the inverse so a stale level is never trusted
    always @(negedge fast_run) fast_pin = ~fast_pin;
    always @(negedge slow_run) slow_pin = ~slow_pin;
endmodule // ccs_osc_model

/* test/ccs_chk_assertions.sv */
`timescale 1ns/1ps
`include "ccs_defs.svh"

// ==========================================================
// Port checks of the clock source block
module ccs_chk #(
    parameter int unsigned FRC_START_CYC = 4
) (
    input wire logic                   core_clk,
    input wire logic                   arst_n,
    input wire logic                   fast_ext_osc_enable,
    input wire logic                   fast_ext_bypass_select,
    input wire logic                   fast_rc_enable,
    input wire logic                   slow_rc_enable,
    input wire logic                   deep_low_power,
    input wire ccs_pkg::ccs_src_bits_t ready_irq_enable,
    input wire logic                   fast_osc_output_pin_en,
    input wire logic [`CCS_CAL_W-1:0]  fast_rc_cal,
    input wire ccs_pkg::ccs_src_bits_t ready_flags,
    input wire ccs_pkg::ccs_src_bits_t ready_irq_req,
    input wire logic                   fast_external_clock,
    input wire logic                   slow_external_clock,
    input wire logic                   fast_internal_rc_clock,
    input wire logic                   slow_internal_rc_clock
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    property p_fxo_gate;
        !ready_flags.fxo |-> !fast_external_clock;
    endproperty
    a_fxo_gate: assert property (p_fxo_gate)
        else $error("fast external clock passed before ready");
    property p_sxo_gate;
        !ready_flags.sxo |-> !slow_external_clock;
    endproperty
    a_sxo_gate: assert property (p_sxo_gate)
        else $error("slow external clock passed before ready");
    property p_frc_gate;
        !ready_flags.frc |-> !fast_internal_rc_clock;
    endproperty
    a_frc_gate: assert property (p_frc_gate)
        else $error("fast rc clock passed before ready");
    property p_src_gate;
        !ready_flags.src |-> !slow_internal_rc_clock;
    endproperty
    a_src_gate: assert property (p_src_gate)
        else $error("slow rc clock passed before ready");
    property p_fxo_irq;
        $rose(ready_flags.fxo) && ready_irq_enable.fxo |=> ready_irq_req.fxo;
    endproperty
    a_fxo_irq: assert property (p_fxo_irq)
        else $error("fast external ready request missing");
    property p_src_irq;
        $rose(ready_flags.src) && ready_irq_enable.src |=> ready_irq_req.src ##1 !ready_irq_req.src;
    endproperty
    a_src_irq: assert property (p_src_irq)
        else $error("slow rc ready request not one pulse");
    property p_frc_off;
        ready_flags.frc && !(fast_rc_enable && !deep_low_power)
            |=> !fast_internal_rc_clock ##1 !ready_flags.frc;
    endproperty
    a_frc_off: assert property (p_frc_off)
        else $error("fast rc stop order wrong");
    property p_src_hold;
        ready_flags.src && slow_rc_enable && deep_low_power |=> ready_flags.src;
    endproperty
    a_src_hold: assert property (p_src_hold)
        else $error("slow rc stopped in low power");
    property p_fxo_amp;
        fast_osc_output_pin_en == (fast_ext_osc_enable && !fast_ext_bypass_select
                                   && !deep_low_power);
    endproperty
    a_fxo_amp: assert property (p_fxo_amp)
        else $error("fast crystal amplifier state wrong");
    // Capture lands on the first edge after release, so look from the third edge on
    property p_cal_hold;
        $past(arst_n, 2) |-> $stable(fast_rc_cal);
    endproperty
    a_cal_hold: assert property (p_cal_hold)
        else $error("calibration changed after capture");
    // Enable first sampled at edge E; flag registered at E+FRC_START_CYC, seen one edge later
    property p_frc_start;
        $rose(ready_flags.frc) |-> $past(fast_rc_enable, FRC_START_CYC + 1)
            && !$past(fast_rc_enable, FRC_START_CYC + 2);
    endproperty
    a_frc_start: assert property (p_frc_start)
        else $error("fast rc ready at wrong cycle");
endmodule // ccs_chk

bind ccs_clock_source_control ccs_chk #(
    .FRC_START_CYC (FRC_START_CYC)
) i_ccs_chk (
    .core_clk               (core_clk),
    .arst_n                 (arst_n),
    .fast_ext_osc_enable    (fast_ext_osc_enable),
    .fast_ext_bypass_select (fast_ext_bypass_select),
    .fast_rc_enable         (fast_rc_enable),
    .slow_rc_enable         (slow_rc_enable),
    .deep_low_power         (deep_low_power),
    .ready_irq_enable       (ready_irq_enable),
    .fast_osc_output_pin_en (fast_osc_output_pin_en),
    .fast_rc_cal            (fast_rc_cal),
    .ready_flags            (ready_flags),
    .ready_irq_req          (ready_irq_req),
    .fast_external_clock    (fast_external_clock),
    .slow_external_clock    (slow_external_clock),
    .fast_internal_rc_clock (fast_internal_rc_clock),
    .slow_internal_rc_clock (slow_internal_rc_clock)
);

/* test/tb_top.sv */
`timescale 1ns/1ps

module tb_top;
    localparam int FRC = 4;
    logic                   core_clk;
    logic                   arst_n;
    logic                   fpin;
    logic                   spin;
    logic                   fpin_en;
    logic                   spin_en;
    logic [5:0]             ctl;
    logic [4:0]             trim;
    logic                   dlp;
    logic                   wdg;
    logic [7:0]             fcal;
    ccs_pkg::ccs_src_bits_t ien;
    logic [7:0]             cal;
    ccs_pkg::ccs_src_bits_t flags;
    ccs_pkg::ccs_src_bits_t irq;
    wire logic [3:0]        clks;
    logic [3:0]             clk_prev;
    logic [3:0]             irq_seen;
    logic [3:0]             tog;
    int                     bad_count;
    int                     checked;
    int                     n;
    // Control {fxo en, fxo bypass, sxo en, sxo bypass, frc en, src en}, irq enable,
    // expected flags, amplifier enables, expected request pulses
    logic [19:0]            rows [7];

    ccs_osc_model i_ccs_osc_model (
        .fast_run(fpin_en | (ctl[5] & ctl[4])), .slow_run(spin_en | (ctl[3] & ctl[2])),
        .fast_pin(fpin), .slow_pin(spin));

    ccs_clock_source_control #(
        .FXO_START_EDGES(8), .SXO_START_EDGES(8), .FRC_START_CYC(FRC), .SRC_START_CYC(8)
    ) i_ccs_clock_source_control (
        .core_clk(core_clk), .arst_n(arst_n), .fast_osc_input_pin(fpin),
        .fast_osc_output_pin_en(fpin_en), .slow_osc_input_pin(spin),
        .slow_osc_output_pin_en(spin_en), .fast_ext_osc_enable(ctl[5]),
        .fast_ext_bypass_select(ctl[4]), .slow_ext_osc_enable(ctl[3]),
        .slow_ext_bypass_select(ctl[2]), .fast_rc_enable(ctl[1]), .fast_rc_trim(trim),
        .slow_rc_enable(ctl[0]), .watchdog_force_slow_rc(wdg), .deep_low_power(dlp),
        .factory_cal(fcal), .ready_irq_enable(ien), .fast_rc_cal(cal),
        .ready_flags(flags), .ready_irq_req(irq), .fast_external_clock(clks[3]),
        .slow_external_clock(clks[2]), .fast_internal_rc_clock(clks[1]),
        .slow_internal_rc_clock(clks[0]));

    always #2.5 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        irq_seen <= irq_seen | irq;
        tog      <= tog | (clks ^ clk_prev);
        clk_prev <= clks;
    end

    // ==========================================================
    // Helpers
    task finish_test;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask

    task wait_flags(input logic [3:0] e);
        n = 0;
        while (flags !== e && n < 600) begin
            @(negedge core_clk);
            n++;
        end
        if (flags !== e) begin
            $display("ERROR at %0t got %h expected %h", $time, flags, e);
            bad_count++;
            finish_test;
        end
    endtask

    // Second pass measures one whole half period of the fast rc clock
    task half_len;
        logic v;
        repeat (2) begin
            v = clks[1];
            n = 0;
            while (clks[1] === v && n < 99) begin
                @(negedge core_clk);
                n++;
            end
        end
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        core_clk = 1'b0;
        arst_n = 1'b0;
        {ctl, ien, dlp, wdg, irq_seen, tog, clk_prev} = '0;
        trim = 5'h10;
        fcal = 8'h80;
        bad_count = 0;
        checked = 0;
        rows = '{{6'h20, 4'hf, 4'h8, 2'h2, 4'h8}, {6'h30, 4'h0, 4'h8, 2'h0, 4'h0},
                 {6'h08, 4'hf, 4'h4, 2'h1, 4'h4}, {6'h0c, 4'hf, 4'h4, 2'h0, 4'h4},
                 {6'h02, 4'h2, 4'h2, 2'h0, 4'h2}, {6'h01, 4'he, 4'h1, 2'h0, 4'h0},
                 {6'h2b, 4'hf, 4'hf, 2'h3, 4'hf}};
        repeat (6) @(negedge core_clk);
        arst_n = 1'b1;
        repeat (2) @(negedge core_clk);
        chk(flags, 8'h00);
        chk(cal, 8'h80);
        fcal = 8'h90;
        repeat (3) @(negedge core_clk);
        chk(cal, 8'h80);
        $display("reset test done");
        for (int i = 0; i < 7; i++) begin
            {ctl, ien} = rows[i][19:10];
            irq_seen = 4'h0;
            wait_flags(rows[i][9:6]);
            chk({fpin_en, spin_en}, rows[i][5:4]);
            tog = 4'h0;
            repeat (80) @(negedge core_clk);
            chk(tog & 4'he, rows[i][9:6] & 4'he);
            chk(irq_seen, rows[i][3:0]);
            ctl = 6'h00;
            wait_flags(4'h0);
            $display("row %0d done", i);
        end
        ctl = 6'h02;
        n = 0;
        while (flags.frc !== 1'b1 && n < 50) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk(8'(n), 8'(FRC + 1));
        half_len;
        chk(8'(n), 8'h0c);
        trim = 5'h12;
        half_len;
        chk(8'(n), 8'h0e);
        $display("fast rc timing test done");
        ctl = 6'h03;
        wait_flags(4'h3);
        dlp = 1'b1;
        wait_flags(4'h1);
        wdg = 1'b1;
        ctl = 6'h00;
        repeat (10) @(negedge core_clk);
        chk(flags, 8'h01);
        {wdg, dlp} = 2'b00;
        wait_flags(4'h0);
        $display("low power test done");
        irq_seen = 4'h0;
        ctl = 6'h02;
        repeat (2) @(negedge core_clk);
        ctl = 6'h00;
        repeat (10) @(negedge core_clk);
        chk(flags, 8'h00);
        chk(irq_seen, 8'h00);
        $display("abort test done");
        ctl = 6'h01;
        wait_flags(4'h1);
        ctl = 6'h00;
        arst_n = 1'b0;
        repeat (2) @(negedge core_clk);
        chk(flags, 8'h00);
        chk(clks, 8'h00);
        arst_n = 1'b1;
        repeat (2) @(negedge core_clk);
        chk(cal, 8'h90);
        $display("second reset test done");
        finish_test;
    end
endmodule // tb_top
